// ---- pkg/spb_pkg.sv ----
// Purpose: Shared constants and types of the byte shifter serial port
// Assumes: One byte per transfer, 8 data bits
// Notes:   Half-period counts are in reference clock cycles

package spb_pkg;

	// ****************************************
	// Sizes and counts
	// ****************************************
	localparam int unsigned SPB_BITS     = 8;
	localparam logic [3:0]  SPB_LAST_EDGE = 4'hf;
	localparam logic [2:0]  SPB_LAST_BIT  = 3'h7;
	localparam logic [1:0]  SPB_SYNC_LAT  = 2'h2;

	// Serial clock half periods for each divider
	localparam logic [6:0] SPB_HALF_D2   = 7'h01;
	localparam logic [6:0] SPB_HALF_D4   = 7'h02;
	localparam logic [6:0] SPB_HALF_D8   = 7'h04;
	localparam logic [6:0] SPB_HALF_D16  = 7'h08;
	localparam logic [6:0] SPB_HALF_D32  = 7'h10;
	localparam logic [6:0] SPB_HALF_D64  = 7'h20;
	localparam logic [6:0] SPB_HALF_D128 = 7'h40;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic xfer_irq_enable;
		logic port_enable_bit;
		logic bit_order_select;
		logic master_select_bit;
		logic clock_idle_level;
		logic clock_sample_edge;
		logic rate_sel_hi;
		logic rate_sel_lo;
		logic double_rate_bit;
	} spb_cfg_t;

	typedef struct packed {
		logic xfer_done_flag;
		logic write_collision_flag;
	} spb_stat_t;

	typedef struct packed {
		logic mosi;
		logic miso;
		logic sck;
		logic ss;
	} spb_pins_t;

	typedef enum logic [1:0] {
		SPB_IDLE,
		SPB_RUN,
		SPB_FLUSH
	} spb_mst_t;

	typedef struct packed {
		spb_cfg_t              cfg;
		spb_stat_t             stat;
		spb_mst_t              st;
		logic                  clr_arm;
		logic [6:0]            div_cnt;
		logic [3:0]            edge_cnt;
		logic [1:0]            flush_cnt;
		logic [1:0]            smp_pipe;
		logic                  sck_lvl;
		logic [SPB_BITS-1:0]   tx_sh;
		logic [SPB_BITS-1:0]   rx_sh;
		logic [SPB_BITS-1:0]   tx_buf;
		logic [SPB_BITS-1:0]   rx_buf;
		logic                  ss_s1;
		logic                  ss_s2;
		logic                  miso_s1;
		logic                  miso_s2;
		logic                  tgl_s1;
		logic                  tgl_s2;
		logic                  tgl_s3;
		logic                  slv_act;
		logic                  done_pulse;
	} spb_state_t;

	typedef struct packed {
		logic [2:0]          cnt;
		logic [SPB_BITS-1:0] rx_sh;
	} spb_frm_t;

	typedef struct packed {
		logic                tgl;
		logic [SPB_BITS-1:0] hold;
	} spb_evt_t;

	// ****************************************
	// Values after reset
	// ****************************************
	localparam spb_cfg_t   SPB_CFG_RST   = '0;
	localparam spb_state_t SPB_STATE_RST = '{cfg: '0, stat: '0, st: SPB_IDLE, ss_s1: 1'b1, ss_s2: 1'b1,
	                                         default: '0};
	localparam spb_frm_t   SPB_FRM_RST   = '0;
	localparam spb_evt_t   SPB_EVT_RST   = '0;

	// Half period for {double rate, rate hi, rate lo}
	function automatic logic [6:0] spb_half(input logic [2:0] code);
		logic [6:0] h;
		h = SPB_HALF_D4;
		case (code)
			3'h0: h = SPB_HALF_D4;
			3'h1: h = SPB_HALF_D16;
			3'h2: h = SPB_HALF_D64;
			3'h3: h = SPB_HALF_D128;
			3'h4: h = SPB_HALF_D2;
			3'h5: h = SPB_HALF_D8;
			3'h6: h = SPB_HALF_D32;
			default: h = SPB_HALF_D64;
		endcase
		return h;
	endfunction

endpackage

// ---- rtl/spb_slave_link.sv ----
// Purpose: Slave shifter clocked by the external serial clock
// Assumes: Configuration stays still while the slave is active
// Notes:   Slave select high clears the frame; byte events leave by toggle

`timescale 1ns/1ps

module spb_slave_link (
	// Link side
	input  wire logic                         sclk_i,
	input  wire logic                         ss_n_i,
	input  wire logic                         mosi_i,
	output logic                              miso_o,
	// Configuration from the reference domain
	input  wire logic                         act_i,
	input  wire logic                         clock_idle_level_i,
	input  wire logic                         clock_sample_edge_i,
	input  wire logic                         lsb_first_i,
	input  wire logic [spb_pkg::SPB_BITS-1:0] tx_byte_i,
	// Received byte toward the reference domain
	output logic                              done_tgl_o,
	output logic [spb_pkg::SPB_BITS-1:0]      rx_byte_o
);

	spb_pkg::spb_frm_t              f_q;
	spb_pkg::spb_frm_t              f_d;
	spb_pkg::spb_evt_t              e_q;
	spb_pkg::spb_evt_t              e_d;
	logic                           smp_clk;
	logic                           frm_rst;
	logic [spb_pkg::SPB_BITS-1:0]   byte_in;

	// Sampling edge follows polarity and phase [R19]
	assign smp_clk = sclk_i ^ (clock_idle_level_i ^ clock_sample_edge_i);
	// No shifting while deselected [R07]
	assign frm_rst = ss_n_i | ~act_i;

	always_comb begin
		byte_in = lsb_first_i ? {mosi_i, f_q.rx_sh[7:1]} : {f_q.rx_sh[6:0], mosi_i}; // [R10] [R15]
		f_d = f_q;
		f_d.rx_sh = byte_in;
		f_d.cnt = f_q.cnt + 3'h1;
		e_d = e_q;
		if (f_q.cnt == spb_pkg::SPB_LAST_BIT) begin
			e_d.hold = byte_in; // [R05]
			e_d.tgl = ~e_q.tgl; // [R08]
		end
	end

	always_ff @(posedge smp_clk or posedge frm_rst) begin
		if (frm_rst) begin
			f_q <= spb_pkg::SPB_FRM_RST;
		end else begin
			f_q <= f_d;
		end
	end

	always_ff @(posedge smp_clk or negedge act_i) begin
		if (!act_i) begin
			e_q <= spb_pkg::SPB_EVT_RST;
		end else begin
			e_q <= e_d;
		end
	end

	// Outgoing bit chosen by bit count and order [R09] [R15]
	assign miso_o     = tx_byte_i[lsb_first_i ? f_q.cnt : ~f_q.cnt];
	assign done_tgl_o = e_q.tgl;
	assign rx_byte_o  = e_q.hold;

	// ****************************************
	// Checks
	// ****************************************
	property p_byte_event;
		// Result is seen at the next link edge, often after deselect
		@(posedge smp_clk) disable iff (!act_i)
		(f_q.cnt == spb_pkg::SPB_LAST_BIT) |=> (e_q.tgl != $past(e_q.tgl)) && (e_q.hold == $past(byte_in));
	endproperty
	a_byte_event: assert property (p_byte_event) else $error("slave byte end without event"); // [R08]

endmodule

// ---- rtl/spb_port.sv ----
// Purpose: Byte shifter serial port, master or slave, full duplex
// Assumes: Software strobes are one reference clock wide
// Notes:   Master serial input is sampled two cycles late through its synchroniser
//
// Function
// R01: Software drives slave select in master role
// R02: Master data write starts eight-bit shift
// R03: Master stops clock, flags done, requests interrupt
// R04: Software writes next byte or ends packet
// R05: Last received byte kept in buffer
// R06: Deselected slave idle, slave-out not driven
// R07: Slave shifts nothing while deselected
// R08: Slave byte end flags done, requests interrupt
// R09: Slave may load next byte before reading
// R10: Master-out carries toward slave, slave-out back
// R11: Software waits for shift end before writing
// R12: Software reads byte before next completes
// R13: External clock at most quarter reference clock
// R14: Enabled port forces documented pin directions
// R15: Selectable first bit, low or high
// R16: Double rate master mode, half reference clock
// R17: Completed transfer wakes processor from idle
// R18: Master rate from double and rate bits
// R19: Clock idle level and sampling edge selectable
// R20: Select low in master role forces slave
// R21: Data write during transfer flags collision; code flags it in master role only, slave-role writes load tx_buf
// R22: Reset leaves port disabled, idle, flags clear

`timescale 1ns/1ps

module spb_port (
	// Clock and reset
	input  wire logic                         ref_clk_i,
	input  wire logic                         rst_n_i,
	// Link pins
	input  wire logic                         sclk_i,
	input  wire logic                         ss_n_i,
	input  wire logic                         mosi_i,
	input  wire logic                         miso_i,
	output logic                              sck_o,
	output logic                              mosi_o,
	output logic                              miso_o,
	output spb_pkg::spb_pins_t                oe_n_o,
	// Software direction choices
	input  spb_pkg::spb_pins_t                dir_i,
	// Control
	input  wire logic                         ctrl_wr_i,
	input  spb_pkg::spb_cfg_t                 ctrl_i,
	output spb_pkg::spb_cfg_t                 ctrl_o,
	// Data and status
	input  wire logic                         data_wr_i,
	input  wire logic [spb_pkg::SPB_BITS-1:0] data_i,
	input  wire logic                         data_rd_i,
	output logic [spb_pkg::SPB_BITS-1:0]      rx_data_o,
	input  wire logic                         status_rd_i,
	output spb_pkg::spb_stat_t                stat_o,
	// Events
	output logic                              irq_o,
	output logic                              wake_o
);

	spb_pkg::spb_state_t            s_q;
	spb_pkg::spb_state_t            s_d;
	logic [6:0]                     half;
	logic                           smp;
	logic                           busy;
	logic                           abort;
	logic                           lk_miso;
	logic                           lk_tgl;
	logic [spb_pkg::SPB_BITS-1:0]   lk_rx;

	// ****************************************
	// Slave shifter on the link clock
	// ****************************************
	spb_slave_link u_link (
		.sclk_i      (sclk_i),
		.ss_n_i      (ss_n_i),
		.mosi_i      (mosi_i),
		.miso_o      (lk_miso),
		.act_i       (s_q.slv_act),
		.clock_idle_level_i      (s_q.cfg.clock_idle_level),
		.clock_sample_edge_i      (s_q.cfg.clock_sample_edge),
		.lsb_first_i (s_q.cfg.bit_order_select),
		.tx_byte_i   (s_q.tx_buf),
		.done_tgl_o  (lk_tgl),
		.rx_byte_o   (lk_rx)
	);

	assign half  = spb_pkg::spb_half({s_q.cfg.double_rate_bit, s_q.cfg.rate_sel_hi, s_q.cfg.rate_sel_lo}); // [R16] [R18]
	assign busy  = s_q.st != spb_pkg::SPB_IDLE;
	// Select pulled low by another master [R20]
	assign abort = s_q.cfg.port_enable_bit && s_q.cfg.master_select_bit && !dir_i.ss && !s_q.ss_s2;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		smp = 1'b0;
		s_d.ss_s1 = ss_n_i;
		s_d.ss_s2 = s_q.ss_s1;
		s_d.miso_s1 = miso_i;
		s_d.miso_s2 = s_q.miso_s1;
		s_d.tgl_s1 = lk_tgl;
		s_d.tgl_s2 = s_q.tgl_s1;
		s_d.tgl_s3 = s_q.tgl_s2;
		s_d.done_pulse = 1'b0;
		s_d.slv_act = s_q.cfg.port_enable_bit && !s_q.cfg.master_select_bit;
		s_d.smp_pipe = {s_q.smp_pipe[0], 1'b0};

		// Delayed sampling matches the synchroniser latency
		if (s_q.smp_pipe[1]) begin
			s_d.rx_sh = s_q.cfg.bit_order_select ? {s_q.miso_s2, s_q.rx_sh[7:1]} // [R10] [R15]
			                                     : {s_q.rx_sh[6:0], s_q.miso_s2};
		end

		// Flags clear on status read then data access; a new set wins
		if (status_rd_i && (s_q.stat.xfer_done_flag || s_q.stat.write_collision_flag)) begin
			s_d.clr_arm = 1'b1;
		end
		if ((data_wr_i || data_rd_i) && s_q.clr_arm) begin
			s_d.stat = '0;
			s_d.clr_arm = 1'b0;
		end

		if (ctrl_wr_i) begin
			s_d.cfg = ctrl_i;
		end

		// Master engine
		unique case (s_q.st)
			spb_pkg::SPB_IDLE: begin
			end
			spb_pkg::SPB_RUN: begin
				if (s_q.div_cnt == half - 7'h01) begin
					s_d.div_cnt = '0;
					smp = s_q.edge_cnt[0] == s_q.cfg.clock_sample_edge; // [R19]
					s_d.sck_lvl = ~s_q.sck_lvl;
					s_d.smp_pipe[0] = smp;
					if (!smp && !(s_q.cfg.clock_sample_edge && s_q.edge_cnt == 4'h0)) begin
						s_d.tx_sh = s_q.cfg.bit_order_select ? {1'b0, s_q.tx_sh[7:1]} : {s_q.tx_sh[6:0], 1'b0};
					end
					s_d.edge_cnt = s_q.edge_cnt + 4'h1;
					if (s_q.edge_cnt == spb_pkg::SPB_LAST_EDGE) begin
						s_d.st = spb_pkg::SPB_FLUSH; // [R02]
						s_d.flush_cnt = '0;
					end
				end else begin
					s_d.div_cnt = s_q.div_cnt + 7'h01;
				end
			end
			spb_pkg::SPB_FLUSH: begin
				s_d.flush_cnt = s_q.flush_cnt + 2'h1;
				if (s_q.flush_cnt == spb_pkg::SPB_SYNC_LAT) begin
					s_d.st = spb_pkg::SPB_IDLE; // [R03]
					s_d.rx_buf = s_q.rx_sh; // [R05]
					s_d.stat.xfer_done_flag = 1'b1; // [R03]
					s_d.done_pulse = 1'b1;
				end
			end
			default: begin
			end
		endcase

		// Software data write
		if (data_wr_i) begin
			if (busy) begin
				s_d.stat.write_collision_flag = 1'b1; // [R21]
			end else begin
				s_d.tx_buf = data_i; // [R09]
				if (s_q.cfg.port_enable_bit && s_q.cfg.master_select_bit) begin
					s_d.st = spb_pkg::SPB_RUN; // [R02]
					s_d.tx_sh = data_i;
					s_d.rx_sh = '0;
					s_d.div_cnt = '0;
					s_d.edge_cnt = '0;
					s_d.sck_lvl = 1'b0;
				end
			end
		end

		// Slave byte arrived
		// Toggle cleared by disabling the slave is no byte
		if (s_q.slv_act && s_q.tgl_s3 != s_q.tgl_s2) begin
			s_d.rx_buf = lk_rx; // [R05]
			s_d.stat.xfer_done_flag = 1'b1; // [R08]
			s_d.done_pulse = 1'b1;
		end

		if (!s_q.cfg.port_enable_bit || !s_q.cfg.master_select_bit) begin
			s_d.st = spb_pkg::SPB_IDLE;
			s_d.sck_lvl = 1'b0;
			s_d.smp_pipe = '0;
		end

		if (abort) begin
			s_d.cfg.master_select_bit = 1'b0; // [R20]
			s_d.stat.xfer_done_flag = 1'b1;
			s_d.done_pulse = 1'b1;
			s_d.st = spb_pkg::SPB_IDLE;
			s_d.sck_lvl = 1'b0;
			s_d.smp_pipe = '0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			s_q <= spb_pkg::SPB_STATE_RST; // [R22]
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs and pin overrides
	// ****************************************
	always_comb begin
		oe_n_o.mosi = !dir_i.mosi;
		oe_n_o.miso = !dir_i.miso;
		oe_n_o.sck  = !dir_i.sck;
		oe_n_o.ss   = !dir_i.ss;
		if (s_q.cfg.port_enable_bit && s_q.cfg.master_select_bit) begin
			oe_n_o.miso = 1'b1; // [R14]
		end else if (s_q.cfg.port_enable_bit) begin
			oe_n_o.mosi = 1'b1; // [R14]
			oe_n_o.sck  = 1'b1;
			oe_n_o.ss   = 1'b1;
			oe_n_o.miso = !(dir_i.miso && !s_q.ss_s2); // [R06]
		end
	end

	assign sck_o     = s_q.sck_lvl ^ s_q.cfg.clock_idle_level; // [R19]
	assign mosi_o    = s_q.cfg.bit_order_select ? s_q.tx_sh[0] : s_q.tx_sh[7]; // [R10] [R15]
	assign miso_o    = lk_miso;
	assign ctrl_o    = s_q.cfg;
	assign stat_o    = s_q.stat;
	assign rx_data_o = s_q.rx_buf;
	assign irq_o     = s_q.stat.xfer_done_flag && s_q.cfg.xfer_irq_enable; // [R03] [R08]
	assign wake_o    = s_q.done_pulse; // [R17]

	// ****************************************
	// Checks
	// ****************************************
	logic [7:0] gap_q;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || s_q.st != spb_pkg::SPB_RUN || s_d.sck_lvl != s_q.sck_lvl) begin
			gap_q <= 8'h01;
		end else begin
			gap_q <= gap_q + 8'h01;
		end
	end

	sequence s_start;
		s_q.cfg.port_enable_bit && s_q.cfg.master_select_bit && data_wr_i && !busy && !abort;
	endsequence

	sequence s_finish;
		s_q.st == spb_pkg::SPB_FLUSH && s_q.flush_cnt == spb_pkg::SPB_SYNC_LAT && !abort;
	endsequence

	property p_start;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_start |=> s_q.st == spb_pkg::SPB_RUN && s_q.edge_cnt == 4'h0 && s_q.tx_sh == $past(data_i);
	endproperty
	a_start: assert property (p_start) else $error("master write did not start shift"); // [R02]

	property p_finish;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_finish |=> s_q.st == spb_pkg::SPB_IDLE && s_q.stat.xfer_done_flag && wake_o;
	endproperty
	a_finish: assert property (p_finish) else $error("master end did not flag done"); // [R03]

	property p_sck_idle;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(s_q.st == spb_pkg::SPB_IDLE) |-> sck_o == s_q.cfg.clock_idle_level;
	endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("serial clock not at idle level"); // [R03]

	property p_rate;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(s_q.st == spb_pkg::SPB_RUN && s_d.sck_lvl != s_q.sck_lvl && !ctrl_wr_i) |-> gap_q == {1'b0, half};
	endproperty
	a_rate: assert property (p_rate) else $error("serial clock half period wrong"); // [R18]

	property p_irq;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		wake_o |-> s_q.stat.xfer_done_flag && (irq_o == s_q.cfg.xfer_irq_enable);
	endproperty
	a_irq: assert property (p_irq) else $error("done event without matching interrupt"); // [R03] [R08]

	property p_desel;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(s_q.cfg.port_enable_bit && !s_q.cfg.master_select_bit && s_q.ss_s2) |-> oe_n_o.miso;
	endproperty
	a_desel: assert property (p_desel) else $error("deselected slave drives slave-out"); // [R06]

	property p_dirs;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_q.cfg.port_enable_bit |-> (s_q.cfg.master_select_bit ? oe_n_o.miso : (oe_n_o.mosi && oe_n_o.sck && oe_n_o.ss));
	endproperty
	a_dirs: assert property (p_dirs) else $error("pin direction not overridden"); // [R14]

	property p_abort;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		abort |=> !s_q.cfg.master_select_bit && s_q.stat.xfer_done_flag && s_q.st == spb_pkg::SPB_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("select low did not force slave"); // [R20]

	property p_write_collision_flag;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(data_wr_i && busy && !abort) |=> s_q.stat.write_collision_flag && s_q.tx_buf == $past(s_q.tx_buf);
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged"); // [R21]

	property p_slave_rx;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(s_q.slv_act && s_q.tgl_s3 != s_q.tgl_s2) |=> s_q.rx_buf == $past(lk_rx) && s_q.stat.xfer_done_flag;
	endproperty
	a_slave_rx: assert property (p_slave_rx) else $error("slave byte not buffered"); // [R05]

	property p_first_bit;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_start ##1 !ctrl_wr_i |-> mosi_o == (s_q.cfg.bit_order_select ? $past(data_i[0]) : $past(data_i[7]));
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("wrong first bit"); // [R15]

endmodule

// ---- verif/spb_peer.sv ----
// Purpose: Far-side serial peer, slave toward a master port, master toward a slave port
// Assumes: One byte per frame, only one role active at a time
// Notes:   Released data lines show the inverse of their last value

`timescale 1ns/1ps

module spb_peer #(
	parameter realtime HALF_NS = 80.0
) (
	// Shared settings
	input  wire logic       clock_idle_level_i,
	input  wire logic       clock_sample_edge_i,
	input  wire logic       lsb_i,
	// Slave role
	input  wire logic       sel_n_i,
	input  wire logic       sck_i,
	input  wire logic       mosi_i,
	input  wire logic [7:0] rsp_i,
	output logic            miso_o,
	output logic [7:0]      rx_o,
	// Master role
	input  wire logic       miso_i,
	output logic            sclk_o,
	output logic            ss_n_o,
	output logic            mosi_o
);
	logic [3:0] idx;
	wire        smp = sck_i ^ clock_idle_level_i ^ clock_sample_edge_i;

	function automatic logic pick(input logic [7:0] b, input logic [2:0] i);
		return lsb_i ? b[i] : b[3'h7 - i];
	endfunction

	function automatic logic [7:0] push(input logic [7:0] r, input logic b);
		return lsb_i ? {b, r[7:1]} : {r[6:0], b};
	endfunction

	initial begin
		miso_o = 1'b0;
		rx_o = 8'h00;
		idx = 4'h0;
		sclk_o = 1'b0;
		ss_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// ****************************************
	// Slave role
	// ****************************************
	always @(negedge sel_n_i) begin
		idx = {3'h0, ~clock_sample_edge_i};
		if (!clock_sample_edge_i)
			miso_o = pick(rsp_i, 3'h0);
	end

	always @(posedge sel_n_i) miso_o = ~miso_o;

	always @(posedge smp) if (!sel_n_i) rx_o = push(rx_o, mosi_i);

	always @(negedge smp) if (!sel_n_i && idx < 4'h8) begin
		miso_o = pick(rsp_i, idx[2:0]);
		idx = idx + 4'h1;
	end

	// ****************************************
	// Master role
	// ****************************************
	task automatic mst_xfer(input logic [7:0] b, input logic sel, output logic [7:0] got);
		int i;
		got = 8'h00;
		sclk_o = clock_idle_level_i;
		#7;
		ss_n_o = ~sel;
		mosi_o = pick(b, 3'h0);
		for (i = 0; i < 8; i++) begin
			#(HALF_NS);
			if (clock_sample_edge_i)
				mosi_o = pick(b, i[2:0]);
			sclk_o = ~sclk_o;
			if (!clock_sample_edge_i)
				got = push(got, miso_i);
			#(HALF_NS);
			sclk_o = ~sclk_o;
			if (clock_sample_edge_i)
				got = push(got, miso_i);
			else if (i < 7)
				mosi_o = pick(b, i[2:0] + 3'h1);
		end
		#(HALF_NS);
		ss_n_o = 1'b1;
		mosi_o = ~mosi_o;
	endtask
endmodule

// ---- verif/spb_port_tb.sv ----
// Purpose: Self-checking bench of the byte shifter serial port
// Assumes: Peer model stands on the far side of the link
// Notes:   Completions are compared against a queue of expected results

`timescale 1ns/1ps

module spb_port_tb;
	// ****************************************
	// Signals
	// ****************************************
	localparam int DIV [8] = '{4, 16, 64, 128, 2, 8, 32, 64};

	logic               ref_clk_i;
	logic               rst_n_i;
	logic               ctrl_wr_i;
	spb_pkg::spb_cfg_t  ctrl_i;
	spb_pkg::spb_cfg_t  ctrl_o;
	logic               data_wr_i;
	logic [7:0]         data_i;
	logic               data_rd_i;
	logic               status_rd_i;
	logic [7:0]         rx_data_o;
	spb_pkg::spb_stat_t stat_o;
	spb_pkg::spb_pins_t oe_n_o;
	spb_pkg::spb_pins_t dir_i;
	logic               irq_o;
	logic               wake_o;
	logic               sck_o;
	logic               mosi_o;
	logic               miso_o;
	logic               p_sclk;
	logic               p_ss_n;
	logic               p_mosi;
	logic               p_miso;
	logic               clock_idle_level_q;
	logic               clock_sample_edge_q;
	logic               lsb_q;
	logic               sel_n_q;
	logic               abort_q;
	logic               flip_q;
	logic [7:0]         rsp_q;
	logic [7:0]         p_rx;
	logic [7:0]         last_rx;
	logic [8:0]         exq[$];
	logic [31:0]        seed;
	int                 failures;
	int                 checked;
	int                 cyc;
	wire                line_miso = (oe_n_o.miso === 1'b0) ? miso_o : flip_q;
	wire                ss_line = p_ss_n & ~abort_q;

	spb_port uut (
		.ref_clk_i   (ref_clk_i),
		.rst_n_i     (rst_n_i),
		.sclk_i      (p_sclk),
		.ss_n_i      (ss_line),
		.mosi_i      (p_mosi),
		.miso_i      (p_miso),
		.sck_o       (sck_o),
		.mosi_o      (mosi_o),
		.miso_o      (miso_o),
		.oe_n_o      (oe_n_o),
		.dir_i       (dir_i),
		.ctrl_wr_i   (ctrl_wr_i),
		.ctrl_i      (ctrl_i),
		.ctrl_o      (ctrl_o),
		.data_wr_i   (data_wr_i),
		.data_i      (data_i),
		.data_rd_i   (data_rd_i),
		.rx_data_o   (rx_data_o),
		.status_rd_i (status_rd_i),
		.stat_o      (stat_o),
		.irq_o       (irq_o),
		.wake_o      (wake_o)
	);

	spb_peer peer (
		.clock_idle_level_i  (clock_idle_level_q),
		.clock_sample_edge_i  (clock_sample_edge_q),
		.lsb_i   (lsb_q),
		.sel_n_i (sel_n_q),
		.sck_i   (sck_o),
		.mosi_i  (mosi_o),
		.rsp_i   (rsp_q),
		.miso_o  (p_miso),
		.rx_o    (p_rx),
		.miso_i  (line_miso),
		.sclk_o  (p_sclk),
		.ss_n_o  (p_ss_n),
		.mosi_o  (p_mosi)
	);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction

	task automatic end_sim;
		if (failures == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_ctrl(input spb_pkg::spb_cfg_t c);
		@(posedge ref_clk_i) begin
			ctrl_wr_i <= 1'b1;
			ctrl_i <= c;
		end
		@(posedge ref_clk_i) ctrl_wr_i <= 1'b0;
	endtask

	task automatic wr_data(input logic [7:0] d);
		@(posedge ref_clk_i) begin
			data_wr_i <= 1'b1;
			data_i <= d;
		end
		@(posedge ref_clk_i) data_wr_i <= 1'b0;
	endtask

	task automatic clr;
		@(posedge ref_clk_i) status_rd_i <= 1'b1;
		@(posedge ref_clk_i) begin
			status_rd_i <= 1'b0;
			data_rd_i <= 1'b1;
		end
		@(posedge ref_clk_i) data_rd_i <= 1'b0;
		@(negedge ref_clk_i) chk({stat_o, irq_o}, 16'h0);
	endtask

	task automatic wait_q;
		int k;
		for (k = 0; k < 50 && exq.size() > 0; k++)
			@(negedge ref_clk_i);
		chk(exq.size(), 16'h0);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic mst(input int i);
		spb_pkg::spb_cfg_t c;
		logic [7:0]        tx;
		int                n;
		c = spb_pkg::spb_cfg_t'({i[0] ^ i[1], 1'b1, i[2] ^ i[0], 1'b1, i[0], i[1], i[1], i[0], i[2]});
		seed = xs(seed);
		tx = seed[7:0];
		wr_ctrl(c);
		@(posedge ref_clk_i) begin
			dir_i <= spb_pkg::spb_pins_t'(seed[19:16]);
			{clock_idle_level_q, clock_sample_edge_q, lsb_q} <= {c.clock_idle_level, c.clock_sample_edge, c.bit_order_select};
			rsp_q <= seed[15:8];
		end
		@(negedge ref_clk_i) chk({oe_n_o.miso, oe_n_o.mosi, oe_n_o.sck}, {1'b1, ~seed[19], ~seed[17]});
		@(posedge ref_clk_i) sel_n_q <= 1'b0;
		exq.push_back({c.xfer_irq_enable, seed[15:8]});
		last_rx = seed[15:8];
		wr_data(tx);
		n = 0;
		while (n < 1100 && wake_o !== 1'b1) begin
			@(posedge ref_clk_i) begin
				data_wr_i <= (i == 1 && n == 3);
				data_i <= ~tx;
			end
			@(negedge ref_clk_i) n++;
		end
		chk(n, 16 * (DIV[i] / 2) + 3);
		chk(stat_o.write_collision_flag, i == 1);
		chk(p_rx, tx);
		@(posedge ref_clk_i) sel_n_q <= 1'b1;
		clr;
	endtask

	task automatic abort;
		wr_ctrl(spb_pkg::spb_cfg_t'(9'h1a0));
		@(posedge ref_clk_i) begin
			dir_i <= 4'he;
			abort_q <= 1'b1;
		end
		exq.push_back({1'b1, last_rx});
		wait_q;
		chk({ctrl_o.master_select_bit, oe_n_o.mosi, oe_n_o.sck}, 16'h3);
		@(posedge ref_clk_i) abort_q <= 1'b0;
		clr;
	endtask

	task automatic slv(input int j);
		spb_pkg::spb_cfg_t c;
		logic [7:0]        ts;
		logic [7:0]        g;
		c = spb_pkg::spb_cfg_t'({j[0], 1'b1, j[1] ^ j[0], 1'b0, j[0], j[1], 3'h0});
		wr_ctrl(c);
		@(posedge ref_clk_i) begin
			dir_i <= 4'h4;
			{clock_idle_level_q, clock_sample_edge_q, lsb_q} <= {c.clock_idle_level, c.clock_sample_edge, c.bit_order_select};
		end
		repeat (3) @(posedge ref_clk_i);
		@(negedge ref_clk_i) chk(oe_n_o, 16'hf);
		seed = xs(seed);
		ts = seed[7:0];
		wr_data(ts);
		peer.mst_xfer(seed[15:8], 1'b0, g);
		exq.push_back({c.xfer_irq_enable, seed[23:16]});
		last_rx = seed[23:16];
		peer.mst_xfer(seed[23:16], 1'b1, g);
		wait_q;
		chk(g, ts);
		if (j == 3)
			clr;
	endtask

	// ****************************************
	// Clock, monitor, timeout, sequence
	// ****************************************
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i) flip_q <= ~flip_q;

	// Each byte is taken at its completion, before the next one ends
	always @(negedge ref_clk_i) begin
		if (wake_o === 1'b1) begin
			if (exq.size() == 0) begin
				failures++;
				$display("[FAIL] %0t unexpected completion", $time);
			end else
				chk({stat_o.xfer_done_flag, irq_o, rx_data_o}, {1'b1, exq.pop_front()});
		end
	end

	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			end_sim;
		end
	end

	initial begin
		rst_n_i = 1'b0;
		ctrl_wr_i = 1'b0;
		ctrl_i = '0;
		data_wr_i = 1'b0;
		data_i = 8'h00;
		data_rd_i = 1'b0;
		status_rd_i = 1'b0;
		dir_i = 4'h5;
		{clock_idle_level_q, clock_sample_edge_q, lsb_q, abort_q, flip_q} = 5'h00;
		sel_n_q = 1'b1;
		rsp_q = 8'h00;
		last_rx = 8'h00;
		seed = 32'd61323;
		failures = 0;
		checked = 0;
		cyc = 0;
		repeat (4) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		@(negedge ref_clk_i) chk({ctrl_o, stat_o, irq_o, wake_o}, 16'h0);
		chk(oe_n_o, 16'ha);
		for (int i = 0; i < 8; i++)
			mst(i);
		abort;
		for (int j = 0; j < 4; j++)
			slv(j);
		end_sim;
	end
endmodule
